// [src/hsr_pkg.sv]
// Package of constants and types for the hot-swap rail sequencer
package hsr_pkg;

  // ****************************************************************
  // Channel count and order (index 0 ramps first)
  // ****************************************************************
  localparam int unsigned NUM_CH = 4; // 5.15 V, 5 V, 3.3 V, negative
  localparam logic [1:0] CH_FIRST = 2'h0; // First rail in the order
  localparam logic [1:0] CH_LAST = 2'h3; // Last rail in the order

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 25000000; // Reference clock rate
  localparam int unsigned REQ_FILT_US = 100; // Request filter time
  // Least time in whole cycles, never below one
  localparam int unsigned REQ_FILT_CYC =
    (REQ_FILT_US * (CLK_HZ / 1000000) + 0) > 0 ?
    REQ_FILT_US * (CLK_HZ / 1000000) : 1;
  localparam int unsigned FILT_W = 12; // Filter counter width
  localparam logic [FILT_W-1:0] FILT_MAX =
    FILT_W'(REQ_FILT_CYC - 1); // Terminal count of the filter

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_REQ_N = 1'b1; // Filtered request idles high
  localparam logic RST_OK_N = 1'b1; // Power-good idles released
  localparam logic [NUM_CH-1:0] RST_DRIVE = 4'h0; // Switches off

  // ****************************************************************
  // Sequencer states, Gray coded from sleep through ramp-down
  // ****************************************************************
  typedef enum logic [2:0] {
    HSR_SLEEP = 3'h0, // Off, low power
    HSR_CHECK = 3'h1, // Validating input rails
    HSR_RAMP_UP = 3'h3, // Ramping current channel
    HSR_ON = 3'h2, // All rails good
    HSR_RAMP_DN = 3'h6, // Ramping off in reverse
    HSR_FAULT = 3'h7 // Latched off
  } hsr_state_t;

endpackage

// [src/hsr_rail_sequencer.sv]
// Sequencing and fault management of a four-rail hot-swap manager
// Functional notes
// - Rails valid and request low: start ramping
// - Request high: all rails off, sleep
// - Fixed order: 5.15V, 5V, 3.3V, negative
// - Check all input windows once before the first channel ramps
// - Ramp timer end: rail outside window faults
// - Keep monitoring load voltage after ramp
// - Peak current during charge: continue, no fault
// - All rails good: drive power-good low
// - Power-good released on any fault or off
// - Any supply missing: all switches off
// - Trip registered at twice peak current
// - Trip: all rails off, latched, power-good released
// - Fault cleared only by request toggle or power
// - Healthy release: ramp off in reverse order
// - Request filtered about 100 us both edges
// - Input window fault before ramp blocks start
// - Window monitoring starts at next channel's ramp
module hsr_rail_sequencer (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Slot controller request, active low
  input wire logic power_req_n_in,
  // Per-channel supply presence (all four, own supply included)
  input wire logic [3:0] supply_present_in,
  // Per-channel window comparators on the muxed voltage
  input wire logic [3:0] low_window_check_in,
  input wire logic [3:0] high_window_check_in,
  // Per-channel current comparators
  input wire logic [3:0] peak_current_limit_in,
  input wire logic [3:0] overcurrent_trip_in,
  // Ramp generator: end of a sawtooth slot
  input wire logic ramp_slot_done_in,
  // Pass switch drives and current-limit select
  output logic [3:0] pass_switch_drive_out,
  output logic [3:0] current_limit_hold_out,
  // Window mux: 1 selects load sense, 0 input sense
  output logic sense_load_sel_out,
  // Ramp generator start and active channel
  output logic ramp_timing_cap_en_out,
  output logic [1:0] active_ch_out,
  // Open-drain power-good
  output logic rails_ok_n_out,
  output logic rails_ok_n_oe_out,
  // Status
  output logic fault_latched_out,
  output logic sleep_out
);

  // ****************************************************************
  // Request filter
  // ****************************************************************
  logic req_filt_n; // Filtered request, low asks for power

  hsr_req_filter u_filt (
    .ref_clk_in (ref_clk_in),
    .rstn_in (rstn_in),
    .raw_n_in (power_req_n_in),
    .filt_n_out (req_filt_n)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    hsr_pkg::hsr_state_t state; // Sequencer state
    logic [1:0] ch; // Channel in its slot
    logic [3:0] drive; // Switches on
    logic [3:0] mon; // Channels under load monitoring
    logic [3:0] hold; // Channels held at peak limit
    logic load_sel; // Window mux select
    logic ramp_en; // Ramp generator active
    logic ok_n; // Power-good level
    logic ok_oe; // Power-good pull-down enabled
    logic fault; // Latched fault
    logic sleep; // Sleep indication
  } hsr_seq_st_t;

  hsr_seq_st_t st_q; // Registered state
  hsr_seq_st_t st_d; // Next state

  // Helper terms
  logic all_present; // Every supply up
  logic [3:0] win_bad; // Window fault per channel
  logic mon_fault; // A monitored load is out of window
  logic oc_any; // Any overcurrent trip

  // Window and current summaries
  always_comb begin
    all_present = &supply_present_in;
    win_bad = low_window_check_in | high_window_check_in;
    mon_fault = |(win_bad & st_q.mon);
    oc_any = |overcurrent_trip_in;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    st_d.hold = st_q.hold | (peak_current_limit_in & st_q.drive);
    unique case (st_q.state)
      // Off: wait for supplies and request
      hsr_pkg::HSR_SLEEP: begin
        st_d.sleep = 1'b1;
        st_d.ok_n = 1'b1;
        st_d.load_sel = 1'b0;
        if (all_present && !req_filt_n) begin
          st_d.state = hsr_pkg::HSR_CHECK;
          st_d.sleep = 1'b0;
        end
      end
      // Inputs must all be in window before the first ramp
      hsr_pkg::HSR_CHECK: begin
        st_d.load_sel = 1'b0;
        if (req_filt_n) begin
          st_d.state = hsr_pkg::HSR_SLEEP;
        end else if (win_bad == 4'h0) begin
          st_d.state = hsr_pkg::HSR_RAMP_UP;
          st_d.ch = hsr_pkg::CH_FIRST;
          st_d.drive = 4'h1;
          st_d.ramp_en = 1'b1;
          st_d.load_sel = 1'b1;
        end
      end
      // One channel ramps per slot, in fixed order
      hsr_pkg::HSR_RAMP_UP: begin
        if (req_filt_n) begin
          st_d.state = hsr_pkg::HSR_SLEEP;
          st_d.drive = hsr_pkg::RST_DRIVE;
          st_d.mon = 4'h0;
          st_d.ramp_en = 1'b0;
        end else if (mon_fault) begin
          st_d.state = hsr_pkg::HSR_FAULT;
        end else if (ramp_slot_done_in) begin
          if (win_bad[st_q.ch]) begin
            st_d.state = hsr_pkg::HSR_FAULT;
          end else begin
            st_d.mon[st_q.ch] = 1'b1;
            if (st_q.ch == hsr_pkg::CH_LAST) begin
              st_d.state = hsr_pkg::HSR_ON;
              st_d.ramp_en = 1'b0;
              st_d.ok_n = 1'b0;
            end else begin
              st_d.ch = st_q.ch + 2'h1;
              st_d.drive[st_q.ch + 2'h1] = 1'b1;
            end
          end
        end
      end
      // Healthy, all rails on and monitored
      hsr_pkg::HSR_ON: begin
        if (mon_fault) begin
          st_d.state = hsr_pkg::HSR_FAULT;
        end else if (req_filt_n) begin
          st_d.state = hsr_pkg::HSR_RAMP_DN;
          st_d.ok_n = 1'b1;
          st_d.ramp_en = 1'b1;
          st_d.mon = 4'h0;
        end
      end
      // Controlled shutdown, last channel first
      hsr_pkg::HSR_RAMP_DN: begin
        if (ramp_slot_done_in) begin
          st_d.drive[st_q.ch] = 1'b0;
          if (st_q.ch == hsr_pkg::CH_FIRST) begin
            st_d.state = hsr_pkg::HSR_SLEEP;
            st_d.ramp_en = 1'b0;
          end else begin
            st_d.ch = st_q.ch - 2'h1;
          end
        end
      end
      // Latched off until request released
      hsr_pkg::HSR_FAULT: begin
        if (req_filt_n) begin
          st_d.state = hsr_pkg::HSR_SLEEP;
          st_d.fault = 1'b0;
        end
      end
      default: begin
        st_d.state = hsr_pkg::HSR_FAULT;
      end
    endcase
    // Overcurrent overrides everything, request release included, while any switch is on
    if (oc_any && st_q.drive != 4'h0) begin
      st_d.state = hsr_pkg::HSR_FAULT;
    end
    // Any entry to fault drops all rails at once
    if (st_d.state == hsr_pkg::HSR_FAULT) begin
      st_d.drive = hsr_pkg::RST_DRIVE;
      st_d.mon = 4'h0;
      st_d.ramp_en = 1'b0;
      st_d.ok_n = 1'b1;
      st_d.fault = (st_q.state != hsr_pkg::HSR_FAULT) | st_q.fault;
      if (st_q.state == hsr_pkg::HSR_FAULT && req_filt_n) begin
        st_d.fault = 1'b0;
      end
    end
    if (st_d.state == hsr_pkg::HSR_FAULT && st_q.state !=
        hsr_pkg::HSR_FAULT) begin
      st_d.fault = 1'b1;
    end
    // Missing supply forces everything off
    if (!all_present) begin
      st_d.drive = hsr_pkg::RST_DRIVE;
      st_d.mon = 4'h0;
      st_d.ramp_en = 1'b0;
      st_d.ok_n = 1'b1;
      if (st_d.state != hsr_pkg::HSR_FAULT) begin
        st_d.state = hsr_pkg::HSR_SLEEP;
      end
    end
    // Limit hold only matters while a switch is on
    st_d.hold = st_d.hold & st_d.drive;
    // Pull-down enable kept in its own flop so the pin has no gate
    st_d.ok_oe = ~st_d.ok_n;
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q.state <= hsr_pkg::HSR_SLEEP;
      st_q.ch <= hsr_pkg::CH_FIRST;
      st_q.drive <= hsr_pkg::RST_DRIVE;
      st_q.mon <= 4'h0;
      st_q.hold <= 4'h0;
      st_q.load_sel <= 1'b0;
      st_q.ramp_en <= 1'b0;
      st_q.ok_n <= hsr_pkg::RST_OK_N;
      st_q.ok_oe <= ~hsr_pkg::RST_OK_N;
      st_q.fault <= 1'b0;
      st_q.sleep <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs straight from flip-flops, except rails_ok_n_out tied low
  // ****************************************************************
  assign pass_switch_drive_out = st_q.drive;
  assign current_limit_hold_out = st_q.hold;
  assign sense_load_sel_out = st_q.load_sel;
  assign ramp_timing_cap_en_out = st_q.ramp_en;
  assign active_ch_out = st_q.ch;
  assign rails_ok_n_out = 1'b0; // Open drain: only pulls low
  assign rails_ok_n_oe_out = st_q.ok_oe;
  assign fault_latched_out = st_q.fault;
  assign sleep_out = st_q.sleep;

endmodule

// [src/hsr_req_filter.sv]
// Request input deglitch filter acting on both edges
module hsr_req_filter (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Raw and filtered request
  input wire logic raw_n_in,
  output logic filt_n_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [hsr_pkg::FILT_W-1:0] cnt; // Cycles input has differed
    logic filt_n; // Accepted level
  } hsr_filt_st_t;

  hsr_filt_st_t st_q; // Registered state
  hsr_filt_st_t st_d; // Next state

  // Count while input differs; accept after full filter time
  always_comb begin
    st_d = st_q;
    if (raw_n_in == st_q.filt_n) begin
      st_d.cnt = '0; // Glitch dropped, restart
    end else if (st_q.cnt == hsr_pkg::FILT_MAX) begin
      st_d.filt_n = raw_n_in;
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q.cnt <= '0;
      st_q.filt_n <= hsr_pkg::RST_REQ_N;
    end else begin
      st_q <= st_d;
    end
  end

  assign filt_n_out = st_q.filt_n;

endmodule

// [test/hsr_rail_sequencer_test.sv]
// Self-checking bench for the rail sequencer
module hsr_rail_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic want = 1'b0; // Power wanted by the slot
  logic req_n, pg_line, slot = 1'b0;
  logic [3:0] present = 4'hF, low_bad = 4'h0, high_bad = 4'h0;
  logic [3:0] peak = 4'h0, trip = 4'h0, drive, hold;
  logic sel, ok_n, ok_oe, fault, sleep;
  logic ramp_on;
  logic [1:0] act_ch;
  int err_count = 0;
  int checks_done = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  hsr_rail_sequencer dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .power_req_n_in(req_n), .supply_present_in(present),
    .low_window_check_in(low_bad), .high_window_check_in(high_bad),
    .peak_current_limit_in(peak), .overcurrent_trip_in(trip),
    .ramp_slot_done_in(slot), .pass_switch_drive_out(drive),
    .current_limit_hold_out(hold), .sense_load_sel_out(sel),
    .ramp_timing_cap_en_out(ramp_on), .active_ch_out(act_ch),
    .rails_ok_n_out(ok_n),
    .rails_ok_n_oe_out(ok_oe), .fault_latched_out(fault), .sleep_out(sleep));
  hsr_slot_model slot_ctl (.ref_clk_in(ref_clk_in), .want_power_in(want),
    .rails_ok_n_in(ok_n), .rails_ok_n_oe_in(ok_oe),
    .power_req_n_out(req_n), .good_line_out(pg_line));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [3:0] seen,
    input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic end_sim();
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bounded wait for a switch pattern; running out ends the run
  task automatic wait_drive(input logic [3:0] exp);
    for (int i = 0; i < 3000 && drive !== exp; i++) tick(1);
    if (drive !== exp) begin
      chk("drive wait", drive, exp);
      end_sim();
    end
  endtask
  // One ramp slot end pulse
  task automatic pulse();
    slot = 1'b1;
    tick(1);
    slot = 1'b0;
    tick(1);
  endtask
  task automatic bring_on();
    want = 1'b1;
    wait_drive(4'h1);
    repeat (4) pulse();
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_ramp_up();
    chk("sleep idle", {3'h0, sleep}, 4'h1);
    want = 1'b1;
    wait_drive(4'h1);
    chk("load sense", {3'h0, sel}, 4'h1);
    chk("ramp run", {3'h0, ramp_on}, 4'h1);
    chk("first ch", {2'h0, act_ch}, 4'h0);
    peak = 4'h1;
    tick(2);
    chk("limit hold", hold, 4'h1);
    chk("no fault", {3'h0, fault}, 4'h0);
    peak = 4'h0;
    pulse();
    chk("rail two", drive, 4'h3);
    pulse();
    chk("rail three", drive, 4'h7);
    chk("good early", {3'h0, ok_oe}, 4'h0);
    pulse();
    chk("rail four", drive, 4'hF);
    chk("last ch", {2'h0, act_ch}, 4'h3);
    pulse();
    chk("power good", {3'h0, pg_line}, 4'h0);
    chk("ramp stop", {3'h0, ramp_on}, 4'h0);
  endtask
  task automatic t_ramp_down();
    want = 1'b0;
    tick(2505);
    chk("good off", {3'h0, pg_line}, 4'h1);
    chk("ramp down run", {3'h0, ramp_on}, 4'h1);
    pulse();
    chk("down one", drive, 4'h7);
    pulse();
    chk("down two", drive, 4'h3);
    pulse();
    chk("down three", drive, 4'h1);
    pulse();
    tick(2);
    chk("all off", drive, 4'h0);
    chk("asleep", {3'h0, sleep}, 4'h1);
  endtask
  task automatic t_trip();
    bring_on();
    trip = 4'h4;
    tick(1);
    chk("trip drive", drive, 4'h0);
    chk("trip good", {3'h0, pg_line}, 4'h1);
    trip = 4'h0;
    tick(10);
    chk("latched", {3'h0, fault}, 4'h1);
    chk("stay off", drive, 4'h0);
    want = 1'b0;
    tick(2505);
    chk("cleared", {fault, 2'h0, sleep}, 4'h1);
  endtask
  task automatic t_window();
    low_bad = 4'h2;
    want = 1'b1;
    tick(2600);
    chk("blocked", drive, 4'h0);
    low_bad = 4'h0;
    wait_drive(4'h1);
    high_bad = 4'h1;
    pulse();
    high_bad = 4'h0;
    chk("timeout", {3'h0, fault}, 4'h1);
    chk("aborted", drive, 4'h0);
    want = 1'b0;
    tick(2505);
    chk("recovered", {3'h0, fault}, 4'h0);
  endtask
  task automatic t_monitor();
    want = 1'b1;
    wait_drive(4'h1);
    pulse();
    high_bad = 4'h4;
    tick(3);
    chk("unwatched", {3'h0, fault}, 4'h0);
    high_bad = 4'h1;
    tick(1);
    chk("watched", {3'h0, fault}, 4'h1);
    high_bad = 4'h0;
    want = 1'b0;
    tick(2505);
    bring_on();
    low_bad = 4'h8;
    tick(1);
    chk("load window", drive, 4'h0);
    chk("load fault", {3'h0, fault}, 4'h1);
    low_bad = 4'h0;
    want = 1'b0;
    tick(2505);
  endtask
  task automatic t_supply();
    bring_on();
    present = 4'hE;
    tick(2);
    chk("supply loss", drive, 4'h0);
    chk("supply good", {3'h0, pg_line}, 4'h1);
    want = 1'b0;
    tick(2505);
    present = 4'hF;
    tick(4);
    chk("still off", drive, 4'h0);
  endtask
  initial begin
    tick(2);
    rstn_in = 1'b1;
    t_ramp_up();
    t_ramp_down();
    t_trip();
    t_window();
    t_monitor();
    t_supply();
    end_sim();
  end
endmodule

// [test/hsr_seq_monitor.sv]
// Port checker for the rail sequencer, bound to its top module
module hsr_seq_monitor (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Inputs of the sequencer
  input wire logic power_req_n_in,
  input wire logic [3:0] supply_present_in,
  input wire logic [3:0] low_window_check_in,
  input wire logic [3:0] high_window_check_in,
  input wire logic [3:0] overcurrent_trip_in,
  // Outputs of the sequencer
  input wire logic [3:0] pass_switch_drive_out,
  input wire logic sense_load_sel_out,
  input wire logic rails_ok_n_oe_out,
  input wire logic fault_latched_out,
  input wire logic sleep_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned low_cnt_q; // Cycles the request has stayed low
  int unsigned high_cnt_q; // Cycles the request has stayed high
  // Request level counters
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_cnt_q <= 0;
      high_cnt_q <= 0;
    end else begin
      low_cnt_q <= power_req_n_in ? 0 : low_cnt_q + 1;
      high_cnt_q <= power_req_n_in ? high_cnt_q + 1 : 0;
    end
  end
  default clocking mon_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Steps of a trip: seen while live, then everything off
  sequence trip_seen;
    (|overcurrent_trip_in) && (|pass_switch_drive_out);
  endsequence
  sequence all_off;
    pass_switch_drive_out == 4'h0 && fault_latched_out && !rails_ok_n_oe_out;
  endsequence
  trip_off_a: assert property (trip_seen |=> all_off)
    else $error("trip did not latch all rails off");
  order_up_a: assert property ((pass_switch_drive_out >
    $past(pass_switch_drive_out)) |-> pass_switch_drive_out ==
    {$past(pass_switch_drive_out[2:0]), 1'b1})
    else $error("rail added out of order");
  order_down_a: assert property ((pass_switch_drive_out <
    $past(pass_switch_drive_out)) |-> (pass_switch_drive_out == 4'h0 ||
    pass_switch_drive_out == ($past(pass_switch_drive_out) >> 1)))
    else $error("rail removed out of order");
  supply_off_a: assert property (supply_present_in != 4'hF
    |-> ##[1:2] pass_switch_drive_out == 4'h0)
    else $error("switch on with a supply missing");
  good_all_a: assert property (rails_ok_n_oe_out |->
    pass_switch_drive_out == 4'hF && !fault_latched_out && !sleep_out)
    else $error("power good without all rails");
  sleep_off_a: assert property (sleep_out |->
    pass_switch_drive_out == 4'h0 && !rails_ok_n_oe_out)
    else $error("rails live in sleep");
  check_block_a: assert property ((!sense_load_sel_out &&
    |(low_window_check_in | high_window_check_in))
    |=> pass_switch_drive_out == 4'h0)
    else $error("ramp began with input out of window");
  filt_start_a: assert property ($rose(|pass_switch_drive_out)
    |-> low_cnt_q >= hsr_pkg::REQ_FILT_CYC)
    else $error("ramp began before request settled");
  fault_clear_a: assert property ($fell(fault_latched_out)
    |-> high_cnt_q >= hsr_pkg::REQ_FILT_CYC)
    else $error("fault cleared without request toggle");
endmodule

bind hsr_rail_sequencer hsr_seq_monitor mon (.ref_clk_in, .rstn_in,
  .power_req_n_in, .supply_present_in, .low_window_check_in,
  .high_window_check_in, .overcurrent_trip_in, .pass_switch_drive_out,
  .sense_load_sel_out, .rails_ok_n_oe_out, .fault_latched_out, .sleep_out);

// [test/hsr_slot_model.sv]
// Slot controller model: request driver and power-good observer
module hsr_slot_model (
  // Clock and command
  input wire logic ref_clk_in,
  input wire logic want_power_in,
  // Open-drain power-good of the sequencer
  input wire logic rails_ok_n_in,
  input wire logic rails_ok_n_oe_in,
  // Request and wired power-good level
  output logic power_req_n_out,
  output logic good_line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic want_q = 1'b0; // Command seen at the last rising edge
  logic pull_low_q = 1'b0; // Controller sinking the request line
  // Take the command away from the falling edge that moves it
  always @(posedge ref_clk_in) begin
    want_q <= want_power_in;
  end
  // Toggling the command is also how a latched fault is recovered
  always @(negedge ref_clk_in) begin
    pull_low_q <= want_q;
  end
  // Board pull-up keeps the request off until power is wanted
  assign power_req_n_out = pull_low_q ? 1'b0 : 1'b1;
  // Pull-up wins when the sequencer lets go of the line
  assign good_line_out = rails_ok_n_oe_in ? rails_ok_n_in : 1'b1;
endmodule
